// ---- hdl/wit_pkg.sv ----
// wit_pkg: addresses, keys, field positions, reset values and carriers
// for the watchdog / interval timer. Assumes a 100 MHz system clock.
// Notes on behaviour
// - reset-control resets on pin/standby, not self
// - watchdog flag sets on wrap, watchdog only
// - watchdog flag clears by zero after read
// - reset disabled: only counter and control reinitialise
// - select bit: zero power-on, one manual
// - reset-control low five bits read one
// - counter/control accept word writes only
// - shared address, high-byte key picks target
// - reset-control accepts word writes only
// - key A5 data 00 clears watchdog flag
// - key 5A copies bits six, five
// - byte reads at three distinct addresses
// - overflow output low for 128 cycles
// - enabled internal reset held 512 cycles
// - pin reset wins, watchdog flag cleared
// - internal reset kept apart from pin reset
// - interval mode interrupts on every overflow
// - interval flag and interrupt same cycle
// - standby refused while timer enabled
// - standby wake counts, wrap releases clock
// - counts only when enabled or waking, else zero
// - three-bit select picks eight clock divisions
// - interval flag clears by zero after read
// - counter write beats same-cycle increment
package wit_pkg;
    // register addresses
    localparam logic [31:0] WIT_ADDR_CTRL = 32'hFFFF_EC10;
    localparam logic [31:0] WIT_ADDR_CNT_RD = 32'hFFFF_EC11;
    localparam logic [31:0] WIT_ADDR_RST_WR = 32'hFFFF_EC12;
    localparam logic [31:0] WIT_ADDR_RST_RD = 32'hFFFF_EC13;
    // write keys
    localparam logic [7:0] WIT_KEY_A = 8'h5A;
    localparam logic [7:0] WIT_KEY_B = 8'hA5;
    localparam logic [7:0] WIT_WATCHDOG_OVERFLOW_FLAG_CLR_DATA = 8'h00;
    // field positions
    localparam int WIT_BIT_FLAG = 7;
    localparam int WIT_BIT_RESET_ENABLE_BIT = 6;
    localparam int WIT_BIT_RESET_SELECT_BIT = 5;
    // reset values and constant-one fields
    localparam logic [7:0] WIT_CNT_RESET = 8'h00;
    localparam logic [7:0] WIT_CNT_MAX = 8'hFF;
    localparam logic [1:0] WIT_CTRL_ONES = 2'h3;
    localparam logic [4:0] WIT_RST_ONES = 5'h1F;
    // timing counts, printed in system clock cycles
    localparam int WIT_OVF_OUT_CYC = 128;
    localparam int WIT_IRST_CYC = 512;
    localparam int WIT_PRESC_W = 13;
    // timer control/status fields
    typedef struct packed {
        logic flag;
        logic mode;
        logic timer_enable_bit;
        logic [2:0] cks;
    } wit_ctrl_t;
    // reset control/status fields
    typedef struct packed {
        logic watchdog_overflow_flag;
        logic reset_enable_bit;
        logic reset_select_bit;
    } wit_rst_t;
    // one bus access, sampled in its last state
    typedef struct packed {
        logic wr;
        logic rd;
        logic word;
        logic [31:0] addr;
        logic [15:0] wdata;
    } wit_bus_t;
endpackage : wit_pkg

// ---- hdl/wit_prescaler.sv ----
// wit_prescaler: divides the system clock, one-cycle tick at the
// selected rate. Assumes run_in and sel_in come from the same clock.
`timescale 1ns/1ps
module wit_prescaler #(
    parameter int WIDTH = 13
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic run_in,
    input wire logic [2:0] sel_in,
    // rate pulse
    output logic tick_out
);
    logic [WIDTH-1:0] div_reg;
    logic [WIDTH-1:0] mask;

    initial begin
        if (WIDTH < 13) begin
            $error("wit_prescaler: WIDTH must be at least 13");
        end
    end

    // low-bit mask for the selected division: 2,64,128,256,512,1024,4096,8192
    function automatic logic [WIDTH-1:0] div_mask(input logic [2:0] sel);
        logic [WIDTH-1:0] m;
        m = '0;
        case (sel)
            3'h0: m[0] = 1'b1;
            3'h1: m[5:0] = '1;
            3'h2: m[6:0] = '1;
            3'h3: m[7:0] = '1;
            3'h4: m[8:0] = '1;
            3'h5: m[9:0] = '1;
            3'h6: m[11:0] = '1;
            default: m[12:0] = '1;
        endcase
        return m;
    endfunction : div_mask

    assign mask = div_mask(sel_in);
    assign tick_out = run_in && ((div_reg & mask) == mask);

    // held at zero while stopped so the first interval is a full one
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg <= '0;
        end else begin
            div_reg <= run_in ? div_reg + 1'b1 : '0;
        end
    end
endmodule : wit_prescaler

// ---- hdl/wit_pulse_stretch.sv ----
// wit_pulse_stretch: turns a start pulse into a level held CYCLES
// cycles; a new start restarts the count. Output is a flop.
`timescale 1ns/1ps
module wit_pulse_stretch #(
    parameter int CYCLES = 128,
    parameter logic IDLE = 1'b0
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // trigger and stretched level
    input wire logic start_in,
    output logic pulse_out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic pulse_reg;

    initial begin
        if (CYCLES < 1) begin
            $error("wit_pulse_stretch: CYCLES must be at least 1");
        end
    end

    assign cnt_next = start_in ? LOAD : ((cnt_reg != '0) ? cnt_reg - 1'b1 : '0);
    assign pulse_out = pulse_reg;

    // active for exactly CYCLES cycles after the start edge
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
            pulse_reg <= IDLE;
        end else begin
            cnt_reg <= cnt_next;
            pulse_reg <= (cnt_next != '0) ? ~IDLE : IDLE;
        end
    end
endmodule : wit_pulse_stretch

// ---- hdl/wit_watchdog_top.sv ----
// wit_watchdog_top: 8-bit watchdog / interval timer with keyed word
// writes and byte reads. Assumes the bus request is held one cycle per
// access on ref_clk_in, rst_n_in is the pin reset, and standby levels
// come from the power controller on the same clock.
`timescale 1ns/1ps
module wit_watchdog_top (
    // clock and pin reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // register access
    input wire wit_pkg::wit_bus_t bus_req_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    // power-down control
    input wire logic hw_standby_in,
    input wire logic sw_standby_in,
    input wire logic nmi_in,
    output logic standby_block_out,
    output logic clock_release_out,
    // overflow pin, interrupt and internal resets
    output logic overflow_out_n,
    output logic interval_interrupt_out,
    output logic wd_power_on_reset_out,
    output logic wd_manual_reset_out
);
    wit_pkg::wit_ctrl_t ctrl_reg;
    wit_pkg::wit_ctrl_t ctrl_next;
    wit_pkg::wit_rst_t rst_reg;
    wit_pkg::wit_rst_t rst_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic flag_seen_reg;
    logic watchdog_overflow_flag_seen_reg;
    logic wake_reg;
    logic release_reg;

    // access decode
    wire [7:0] key = bus_req_in.wdata[15:8];
    wire [7:0] dat = bus_req_in.wdata[7:0];
    wire wr_word = bus_req_in.wr && bus_req_in.word;
    wire hit_shared = wr_word && (bus_req_in.addr == wit_pkg::WIT_ADDR_CTRL);
    wire hit_rst = wr_word && (bus_req_in.addr == wit_pkg::WIT_ADDR_RST_WR);
    wire wr_cnt = hit_shared && (key == wit_pkg::WIT_KEY_A);
    wire wr_ctrl = hit_shared && (key == wit_pkg::WIT_KEY_B);
    wire wr_reset_enable_bit = hit_rst && (key == wit_pkg::WIT_KEY_A);
    wire wr_wclr = hit_rst && (key == wit_pkg::WIT_KEY_B)
                   && (dat == wit_pkg::WIT_WATCHDOG_OVERFLOW_FLAG_CLR_DATA);
    wire rd_byte = bus_req_in.rd && !bus_req_in.word;
    wire rd_ctrl = rd_byte && (bus_req_in.addr == wit_pkg::WIT_ADDR_CTRL);
    wire rd_cnt = rd_byte && (bus_req_in.addr == wit_pkg::WIT_ADDR_CNT_RD);
    wire rd_rst = rd_byte && (bus_req_in.addr == wit_pkg::WIT_ADDR_RST_RD);

    // counting and overflow events
    wire standby_init = hw_standby_in || sw_standby_in;
    wire counting = ctrl_reg.timer_enable_bit || wake_reg;
    wire tick;
    wire wrap = tick && (cnt_reg == wit_pkg::WIT_CNT_MAX) && !wr_cnt;
    wire wd_ovf = wrap && ctrl_reg.timer_enable_bit && ctrl_reg.mode && !standby_init;
    wire iv_ovf = wrap && ctrl_reg.timer_enable_bit && !ctrl_reg.mode && !standby_init;
    wire wake_ovf = wrap && wake_reg;
    wire irst_go = wd_ovf && rst_reg.reset_enable_bit;
    wire flag_clear = wr_ctrl && !dat[wit_pkg::WIT_BIT_FLAG] && flag_seen_reg;
    wire watchdog_overflow_flag_clear = wr_wclr && watchdog_overflow_flag_seen_reg;
    wire [7:0] ctrl_view = {ctrl_reg.flag, ctrl_reg.mode, ctrl_reg.timer_enable_bit,
                            wit_pkg::WIT_CTRL_ONES, ctrl_reg.cks};
    wire [7:0] rst_view = {rst_reg.watchdog_overflow_flag, rst_reg.reset_enable_bit, rst_reg.reset_select_bit,
                           wit_pkg::WIT_RST_ONES};

    // counter: the write takes the slot even when a tick lands with it
    always_comb begin
        cnt_next = cnt_reg;
        if (standby_init && !wake_reg) begin
            cnt_next = wit_pkg::WIT_CNT_RESET;
        end else if (wd_ovf) begin
            cnt_next = wit_pkg::WIT_CNT_RESET;
        end else if (wr_cnt) begin
            cnt_next = dat;
        end else if (!counting) begin
            cnt_next = wit_pkg::WIT_CNT_RESET;
        end else if (tick) begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    // timer control: software standby keeps the clock select for wake-up
    always_comb begin
        ctrl_next = ctrl_reg;
        if (hw_standby_in || wd_ovf) begin
            ctrl_next = '0;
        end else if (sw_standby_in) begin
            ctrl_next.flag = 1'b0;
            ctrl_next.mode = 1'b0;
            ctrl_next.timer_enable_bit = 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_next.mode = dat[6];
                ctrl_next.timer_enable_bit = dat[5];
                ctrl_next.cks = dat[2:0];
            end
            if (flag_clear) begin
                ctrl_next.flag = 1'b0;
            end
            if (iv_ovf) begin
                ctrl_next.flag = 1'b1;
            end
        end
    end

    // reset control: untouched by the block's own internal reset
    always_comb begin
        rst_next = rst_reg;
        if (standby_init) begin
            rst_next = '0;
        end else begin
            if (wr_reset_enable_bit) begin
                rst_next.reset_enable_bit = dat[wit_pkg::WIT_BIT_RESET_ENABLE_BIT];
                rst_next.reset_select_bit = dat[wit_pkg::WIT_BIT_RESET_SELECT_BIT];
            end
            if (watchdog_overflow_flag_clear) begin
                rst_next.watchdog_overflow_flag = 1'b0;
            end
            if (wd_ovf) begin
                rst_next.watchdog_overflow_flag = 1'b1;
            end
        end
    end

    // state registers; the pin reset is the asynchronous reset and wins
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= wit_pkg::WIT_CNT_RESET;
            ctrl_reg <= '0;
            rst_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            ctrl_reg <= ctrl_next;
            rst_reg <= rst_next;
        end
    end

    // read-as-one memory for the clear-only flags
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_seen_reg <= 1'b0;
            watchdog_overflow_flag_seen_reg <= 1'b0;
        end else begin
            flag_seen_reg <= ctrl_next.flag && (flag_seen_reg || (rd_ctrl && ctrl_reg.flag));
            watchdog_overflow_flag_seen_reg <= rst_next.watchdog_overflow_flag && (watchdog_overflow_flag_seen_reg || (rd_rst && rst_reg.watchdog_overflow_flag));
        end
    end

    // byte read data, one cycle after the request; other addresses read zero
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_byte;
            if (rd_ctrl) begin
                rd_data_reg <= ctrl_view;
            end else if (rd_cnt) begin
                rd_data_reg <= cnt_reg;
            end else if (rd_rst) begin
                rd_data_reg <= rst_view;
            end else if (rd_byte) begin
                rd_data_reg <= 8'h00;
            end
        end
    end

    // standby wake: nmi starts the count, the wrap hands the clock back
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_reg <= 1'b0;
            release_reg <= 1'b0;
        end else begin
            release_reg <= wake_ovf;
            if (!sw_standby_in || wake_ovf) begin
                wake_reg <= 1'b0;
            end else if (nmi_in) begin
                wake_reg <= 1'b1;
            end
        end
    end

    wit_prescaler #(
        .WIDTH(wit_pkg::WIT_PRESC_W)
    ) u_presc (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .run_in(counting),
        .sel_in(ctrl_reg.cks),
        .tick_out(tick)
    );

    // overflow pin and the selected reset kind start on the same edge
    wit_pulse_stretch #(
        .CYCLES(wit_pkg::WIT_OVF_OUT_CYC),
        .IDLE(1'b1)
    ) u_ovf_pin (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(wd_ovf),
        .pulse_out(overflow_out_n)
    );

    // separate outputs keep the watchdog reset apart from the pin reset
    wit_pulse_stretch #(
        .CYCLES(wit_pkg::WIT_IRST_CYC),
        .IDLE(1'b0)
    ) u_por (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(irst_go && !rst_reg.reset_select_bit),
        .pulse_out(wd_power_on_reset_out)
    );

    wit_pulse_stretch #(
        .CYCLES(wit_pkg::WIT_IRST_CYC),
        .IDLE(1'b0)
    ) u_manual (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(irst_go && rst_reg.reset_select_bit),
        .pulse_out(wd_manual_reset_out)
    );

    // outputs straight from flops
    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign standby_block_out = ctrl_reg.timer_enable_bit;
    assign clock_release_out = release_reg;
    assign interval_interrupt_out = ctrl_reg.flag;

    // helper: length of the last internal reset level
    logic [9:0] irst_len_reg;
    wire irst_any = wd_power_on_reset_out || wd_manual_reset_out;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irst_len_reg <= 10'h000;
        end else begin
            irst_len_reg <= irst_any ? irst_len_reg + 10'h001 : 10'h000;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_pin_low_start: assert property (wd_ovf |=> !overflow_out_n)
        else $error("overflow pin did not fall after watchdog overflow");
    chk_pin_low_len: assert property (wd_ovf |-> ##129 overflow_out_n)
        else $error("overflow pin not released after 128 cycles");
    chk_irst_len: assert property (irst_any && !$past(irst_any) |-> ##1 irst_any [*8])
        else $error("internal reset dropped early");
    chk_irst_total: assert property ($fell(irst_any) |-> irst_len_reg == 10'h200)
        else $error("internal reset not held 512 cycles");
    chk_irst_kind: assert property (
        irst_go |=> (wd_manual_reset_out == $past(rst_reg.reset_select_bit))
        && (wd_power_on_reset_out != $past(rst_reg.reset_select_bit)))
        else $error("wrong internal reset kind");
    chk_no_irst_off: assert property (wd_ovf && !rst_reg.reset_enable_bit |=> !irst_any || $past(irst_any))
        else $error("internal reset issued while reset disabled");
    chk_watchdog_overflow_flag_cause: assert property ($rose(rst_reg.watchdog_overflow_flag) |-> $past(wd_ovf))
        else $error("watchdog flag set without watchdog overflow");
    chk_iv_irq: assert property (
        iv_ovf |=> ctrl_reg.flag && interval_interrupt_out
        && !rst_reg.watchdog_overflow_flag == !$past(rst_reg.watchdog_overflow_flag))
        else $error("interval overflow did not raise flag and interrupt");
    chk_write_wins: assert property (wr_cnt && tick && !standby_init |=> cnt_reg == $past(dat))
        else $error("counter increment overrode write");
    chk_stop_zero: assert property (!counting && !wr_cnt |=> cnt_reg == 8'h00)
        else $error("counter not zero while stopped");
    chk_bad_key: assert property (
        (hit_shared || hit_rst) && !wr_cnt && !wr_ctrl && !wr_reset_enable_bit
        && !wr_wclr && !standby_init && !wrap
        |=> $stable(rst_reg) && $stable(ctrl_reg.cks))
        else $error("unkeyed write changed a register");
    chk_rst_ones: assert property (rd_rst |=> rd_data_out[4:0] == 5'h1F)
        else $error("reset-control low bits not read as one");

    // wake release, interval pin quiet, read answer and reset-control keeping
    chk_release_pulse: assert property (wake_ovf |=> clock_release_out)
        else $error("clock not released on wake wrap");
    chk_release_one: assert property (
        clock_release_out && !wake_ovf |=> !clock_release_out)
        else $error("clock release longer than one cycle");
    chk_iv_no_pin: assert property (iv_ovf && overflow_out_n |=> overflow_out_n)
        else $error("interval overflow drove the overflow pin");
    chk_rd_answer: assert property (rd_byte |=> rd_valid_out)
        else $error("byte read not answered next cycle");
    chk_rst_keep: assert property (
        irst_go && !wr_reset_enable_bit |=> $stable(rst_reg.reset_enable_bit) && $stable(rst_reg.reset_select_bit))
        else $error("reset control changed by internal reset");
    chk_wclr_keep: assert property (
        wr_wclr && !standby_init |=> $stable(rst_reg.reset_enable_bit) && $stable(rst_reg.reset_select_bit))
        else $error("flag clear touched reset enable or select");

    cov_watchdog_reset: cover property (irst_go);
    cov_interval: cover property (iv_ovf ##[1:1000] flag_clear);
    cov_wake: cover property (wake_ovf);
    cov_watchdog_overflow_flag_clear: cover property (watchdog_overflow_flag_clear);
    cov_write_tick: cover property (wr_cnt && tick);
endmodule : wit_watchdog_top

// ---- verification/wit_cpu_model.sv ----
// wit_cpu_model: stands in for the cpu on the peripheral bus, making keyed
// word writes and byte reads. Assumes one bench thread calls its tasks.
`timescale 1ns/1ps
module wit_cpu_model (
    // clock
    input wire logic ref_clk_in,
    // request and read answer
    output wit_pkg::wit_bus_t bus_req_out,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in
);
    // idle bus at time zero; released lines are inverted below
    initial begin
        bus_req_out = '0;
    end

    // released lines show inverted junk so a stale address never looks valid
    task automatic release_bus();
        bus_req_out.wr <= 1'b0;
        bus_req_out.rd <= 1'b0;
        bus_req_out.addr <= ~bus_req_out.addr;
        bus_req_out.wdata <= ~bus_req_out.wdata;
    endtask : release_bus

    // key in the high byte, data low; word low only when a refusal is wanted
    task automatic write_word(input logic [31:0] addr, input logic [7:0] key,
                              input logic [7:0] data, input logic word);
        @(posedge ref_clk_in);
        bus_req_out <= '{wr: 1'b1, rd: 1'b0, word: word, addr: addr,
                         wdata: {key, data}};
        @(posedge ref_clk_in);
        release_bus();
    endtask : write_word

    // byte read; the answer comes one cycle after the strobe is taken
    task automatic read_byte(input logic [31:0] addr, output logic [7:0] data,
                             output logic valid);
        @(posedge ref_clk_in);
        bus_req_out <= '{wr: 1'b0, rd: 1'b1, word: 1'b0, addr: addr,
                         wdata: 16'h0000};
        @(posedge ref_clk_in);
        release_bus();
        #1;
        data = rd_data_in;
        valid = rd_valid_in;
    endtask : read_byte
endmodule : wit_cpu_model

// ---- verification/wit_watchdog_top_tb_top.sv ----
// wit_watchdog_top_tb_top: self-checking bench for the watchdog timer.
// Assumes the cpu model owns the bus; standby and pin reset driven here.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module wit_watchdog_top_tb_top;
    logic ref_clk_in;
    logic rst_n_in;
    wit_pkg::wit_bus_t bus_req;
    logic [7:0] rd_data;
    logic rd_valid, hw_stby, sw_stby, nmi, stby_block, clk_rel;
    logic ovf_n, irq, por, man;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    wit_watchdog_top wit_watchdog_top_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .bus_req_in(bus_req), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .hw_standby_in(hw_stby), .sw_standby_in(sw_stby), .nmi_in(nmi),
        .standby_block_out(stby_block), .clock_release_out(clk_rel),
        .overflow_out_n(ovf_n), .interval_interrupt_out(irq),
        .wd_power_on_reset_out(por), .wd_manual_reset_out(man));
    wit_cpu_model wit_cpu_model_i (.ref_clk_in(ref_clk_in), .bus_req_out(bus_req),
        .rd_data_in(rd_data), .rd_valid_in(rd_valid));

    // 100 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // hang guard: whole run needs well under 10000 cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // sample after the edge so design updates have landed
    task automatic tick();
        @(posedge ref_clk_in);
        #1;
    endtask : tick

    task automatic wr(input logic [31:0] a, input logic [7:0] k, input logic [7:0] d);
        wit_cpu_model_i.write_word(a, k, d, 1'b1);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        wit_cpu_model_i.read_byte(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, exp)
    endtask : rd_chk

    // one watchdog overflow from FE, then width of pin and reset pulses
    task automatic wd_run(input logic [7:0] rd6, input logic pe, input logic me);
        int lo, pc, mc;
        lo = 0;
        pc = 0;
        mc = 0;
        wr(wit_pkg::WIT_ADDR_RST_WR, wit_pkg::WIT_KEY_A, rd6);
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, {1'b0, rd6[6:5], 5'h1F});
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h60);
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'h78);
        `CHK(stby_block, 1'b1)
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_A, 8'hFE);
        for (int n = 0; n < 40 && ovf_n !== 1'b0; n++) tick();
        `CHK(por, pe)
        `CHK(man, me)
        for (int n = 0; n < 600; n++) begin
            lo += (ovf_n === 1'b0);
            pc += (por === 1'b1);
            mc += (man === 1'b1);
            tick();
        end
        `CHK(lo, 128)
        `CHK(pc, pe ? 512 : 0)
        `CHK(mc, me ? 512 : 0)
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'h18);
        rd_chk(wit_pkg::WIT_ADDR_CNT_RD, 8'h00);
        `CHK(stby_block, 1'b0)
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, {1'b1, rd6[6:5], 5'h1F});
        // a one in the flag, or an unknown key, must leave the flag set
        wr(wit_pkg::WIT_ADDR_RST_WR, wit_pkg::WIT_KEY_B, 8'h80);
        wr(wit_pkg::WIT_ADDR_RST_WR, 8'h3C, 8'h00);
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, {1'b1, rd6[6:5], 5'h1F});
        wr(wit_pkg::WIT_ADDR_RST_WR, wit_pkg::WIT_KEY_B, 8'h00);
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, {1'b0, rd6[6:5], 5'h1F});
    endtask : wd_run

    initial begin
        rst_n_in = 1'b0;
        hw_stby = 1'b0;
        sw_stby = 1'b0;
        nmi = 1'b0;
        repeat (20) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'h18);
        rd_chk(wit_pkg::WIT_ADDR_CNT_RD, 8'h00);
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, 8'h1F);
        rd_chk(32'hFFFF_EC14, 8'h00); // unmapped byte reads zero
        // refused writes: byte size and unknown key
        wit_cpu_model_i.write_word(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h60, 1'b0);
        wit_cpu_model_i.write_word(wit_pkg::WIT_ADDR_RST_WR, wit_pkg::WIT_KEY_A, 8'h60, 1'b0);
        wr(wit_pkg::WIT_ADDR_CTRL, 8'h3C, 8'h60);
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'h18);
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, 8'h1F);
        // interval mode, div2, counter placed near the wrap
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h20);
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_A, 8'hFD);
        for (int n = 0; n < 40 && irq !== 1'b1; n++) tick();
        `CHK(irq, 1'b1)
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'hB8);
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, 8'h1F);
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'hA0);
        tick();
        `CHK(irq, 1'b1)
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h20);
        tick();
        `CHK(irq, 1'b0)
        // counter keeps running: next wrap 512 cycles on
        for (int n = 0; n < 600 && irq !== 1'b1; n++) tick();
        `CHK(irq, 1'b1)
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h00);
        rd_chk(wit_pkg::WIT_ADDR_CNT_RD, 8'h00);
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'h98);
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h00);
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'h18);
        // div64 from FF: quiet at the div2 pace, wraps about 64 cycles on
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h21);
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_A, 8'hFF);
        repeat (40) tick();
        `CHK(irq, 1'b0)
        for (int n = 0; n < 60 && irq !== 1'b1; n++) tick();
        `CHK(irq, 1'b1)
        rd_chk(wit_pkg::WIT_ADDR_CTRL, 8'hB9);
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h00);
        // watchdog overflows: power-on, manual, no internal reset
        wd_run(8'h40, 1'b1, 1'b0);
        wd_run(8'h60, 1'b0, 1'b1);
        wd_run(8'h00, 1'b0, 1'b0);
        // software standby wake on nmi, counted at div2
        wr(wit_pkg::WIT_ADDR_RST_WR, wit_pkg::WIT_KEY_A, 8'h60);
        @(posedge ref_clk_in);
        sw_stby <= 1'b1; // div2 interval outlasts the settling
        nmi <= 1'b1;
        for (int n = 0; n < 700 && clk_rel !== 1'b1; n++) tick();
        `CHK(clk_rel, 1'b1)
        @(posedge ref_clk_in);
        sw_stby <= 1'b0;
        nmi <= 1'b0;
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, 8'h1F);
        // hardware standby reinitialises reset control
        wr(wit_pkg::WIT_ADDR_RST_WR, wit_pkg::WIT_KEY_A, 8'h40);
        @(posedge ref_clk_in);
        hw_stby <= 1'b1;
        @(posedge ref_clk_in);
        hw_stby <= 1'b0;
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, 8'h1F);
        // pin reset lands on the overflow edge itself (second div2 tick) and wins
        wr(wit_pkg::WIT_ADDR_RST_WR, wit_pkg::WIT_KEY_A, 8'h40);
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_B, 8'h60);
        wr(wit_pkg::WIT_ADDR_CTRL, wit_pkg::WIT_KEY_A, 8'hFF);
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        tick();
        `CHK(por, 1'b0)
        `CHK(ovf_n, 1'b1)
        @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd_chk(wit_pkg::WIT_ADDR_RST_RD, 8'h1F);
        conclude();
    end
endmodule : wit_watchdog_top_tb_top
